// ---- design/dnm_rx_mask.sv ----
`timescale 1ns/100ps
`default_nettype none
module dnm_rx_mask #(
  parameter int MASK_WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Register access
  input wire dnm_pkg::dnm_req_t req_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  // Node role and commit
  input wire logic is_target_in,
  input wire logic new_structure_commit_in,
  input wire logic [7:0] local_downstream_slot_count_in,
  // Downstream slot stream
  input wire dnm_pkg::dnm_slot_t slot_in,
  output dnm_pkg::dnm_slot_t sport_out,
  // Status
  output logic [7:0] active_mask_out,
  output logic use_slot_count_out,
  output logic [7:0] slot_count_out
);
  import dnm_pkg::*;

  typedef struct packed {
    logic [7:0] pending;
    logic [7:0] rdata;
    logic rvalid;
    dnm_slot_t sport;
  } dnm_state_t;

  dnm_state_t state;
  dnm_state_t next_state;
  logic [7:0] active;
  logic [7:0] slot_hit;
  logic in_range;
  logic [4:0] rel;
  logic all_zero;
  logic [7:0] slot_dec;
  logic rx_enable_down_slot_16;
  logic rx_enable_down_slot_17;
  logic rx_enable_down_slot_18;
  logic rx_enable_down_slot_19;
  logic rx_enable_down_slot_20;
  logic rx_enable_down_slot_21;
  logic rx_enable_down_slot_22;
  logic rx_enable_down_slot_23;

  // ==========================================
  // Slot decode
  function automatic logic [7:0] slot_onehot(input logic [4:0] slot);
    logic [4:0] r;
    r = slot - DNM_FIRST_SLOT_5;
    slot_onehot = 8'h00;
    if (slot >= DNM_FIRST_SLOT_5 && r < 5'h08) begin
      slot_onehot[r[2:0]] = 1'b1;
    end
  endfunction

  dnm_apply u_apply (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .pending_in(state.pending),
    .commit_in(new_structure_commit_in),
    .active_out(active)
  );

  assign rel = slot_in.slot - DNM_FIRST_SLOT_5;
  assign slot_dec = slot_onehot(slot_in.slot);
  assign in_range = |slot_dec;
  assign all_zero = (active == 8'h00);

  // ==========================================
  // Per-slot enables of the active mask
  assign rx_enable_down_slot_16 = active[0];
  assign rx_enable_down_slot_17 = active[1];
  assign rx_enable_down_slot_18 = active[2];
  assign rx_enable_down_slot_19 = active[3];
  assign rx_enable_down_slot_20 = active[4];
  assign rx_enable_down_slot_21 = active[5];
  assign rx_enable_down_slot_22 = active[6];
  assign rx_enable_down_slot_23 = active[7];

  genvar g;
  generate
    for (g = 0; g < MASK_WIDTH; g++) begin : gen_hit
      assign slot_hit[g] = active[g] & slot_dec[g];
    end
  endgenerate

  // ==========================================
  // Register and slot logic
  always_comb begin
    next_state = state;
    next_state.rvalid = 1'b0;
    next_state.sport.valid = 1'b0;
    if (!nrst_in) begin
      next_state.pending = DNM_MASK_RESET;
      next_state.rdata = 8'h00;
      next_state.sport = '0;
    end else begin
      if (req_in.wr && req_in.addr == DNM_MASK_OFFSET) begin
        next_state.pending = req_in.wdata;
      end
      if (req_in.rd) begin
        next_state.rvalid = 1'b1;
        next_state.rdata = (req_in.addr == DNM_MASK_OFFSET) ? state.pending : 8'h00;
      end
      if (slot_in.valid && is_target_in && in_range && !all_zero && |slot_hit) begin
        next_state.sport.valid = 1'b1;
        next_state.sport.slot = slot_in.slot;
        next_state.sport.data = slot_in.data;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    state <= next_state;
  end

  assign rdata_out = state.rdata;
  assign rvalid_out = state.rvalid;
  assign sport_out = state.sport;
  assign active_mask_out = active;
  assign use_slot_count_out = all_zero | ~is_target_in;
  assign slot_count_out = local_downstream_slot_count_in;

  // ==========================================
  // Checks
  chk_read_pending: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    req_in.rd && req_in.addr == DNM_MASK_OFFSET && !req_in.wr |=> rvalid_out && rdata_out == $past(state.pending))
    else $error("read did not return pending mask");
  chk_write_store: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    req_in.wr && req_in.addr == DNM_MASK_OFFSET ##1 req_in.rd && req_in.addr == DNM_MASK_OFFSET && !req_in.wr
    |=> rdata_out == $past(req_in.wdata, 2)) else $error("write not visible on read");
  chk_accept_bit: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && in_range && active[rel[2:0]]
    |=> sport_out.valid && sport_out.slot == $past(slot_in.slot))
    else $error("enabled slot not forwarded");
  chk_reject_bit: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && in_range && !active[rel[2:0]] |=> !sport_out.valid)
    else $error("disabled slot forwarded");
  chk_controller_off: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !is_target_in |=> !sport_out.valid)
    else $error("controller node forwarded slot");
  chk_zero_count: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    active == 8'h00 |-> use_slot_count_out && !(|slot_hit))
    else $error("zero mask not handed to slot count");
  chk_out_range: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && !in_range |=> !sport_out.valid)
    else $error("out of range slot forwarded");
  chk_no_early: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !new_structure_commit_in |=> active == $past(active))
    else $error("mask applied before commit");
  chk_reset_clear: assert property (@(posedge mclk_in)
    !nrst_in |=> rdata_out == 8'h00 && !rvalid_out && !sport_out.valid && active_mask_out == 8'h00)
    else $error("outputs not cleared by reset");
  chk_rvalid_pulse: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !req_in.rd |=> !rvalid_out)
    else $error("read valid without read request");
  chk_pending_hold: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !(req_in.wr && req_in.addr == DNM_MASK_OFFSET) |=> $stable(state.pending))
    else $error("pending mask changed without write");
  chk_forward_data: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && in_range && active[rel[2:0]] |=> sport_out.data == $past(slot_in.data))
    else $error("forwarded slot data wrong");
  chk_zero_drop: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && active == 8'h00 |=> !sport_out.valid)
    else $error("slot forwarded with zero mask");
  chk_count_pass: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_count_out == local_downstream_slot_count_in)
    else $error("slot count not passed through");

  // ==========================================
  // Per-slot checks
  chk_slot16_accept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && slot_in.slot == DNM_FIRST_SLOT_5 && rx_enable_down_slot_16 |=> sport_out.valid)
    else $error("slot 16 enabled but not forwarded");
  chk_slot17_accept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && slot_in.slot == DNM_FIRST_SLOT_5 + 5'h01 && rx_enable_down_slot_17
    |=> sport_out.valid) else $error("slot 17 enabled but not forwarded");
  chk_slot18_accept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && slot_in.slot == DNM_FIRST_SLOT_5 + 5'h02 && rx_enable_down_slot_18
    |=> sport_out.valid) else $error("slot 18 enabled but not forwarded");
  chk_slot19_accept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && slot_in.slot == DNM_FIRST_SLOT_5 + 5'h03 && rx_enable_down_slot_19
    |=> sport_out.valid) else $error("slot 19 enabled but not forwarded");
  chk_slot20_accept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && slot_in.slot == DNM_FIRST_SLOT_5 + 5'h04 && rx_enable_down_slot_20
    |=> sport_out.valid) else $error("slot 20 enabled but not forwarded");
  chk_slot21_accept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && slot_in.slot == DNM_FIRST_SLOT_5 + 5'h05 && rx_enable_down_slot_21
    |=> sport_out.valid) else $error("slot 21 enabled but not forwarded");
  chk_slot22_accept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && slot_in.slot == DNM_FIRST_SLOT_5 + 5'h06 && rx_enable_down_slot_22
    |=> sport_out.valid) else $error("slot 22 enabled but not forwarded");
  chk_slot23_accept: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    slot_in.valid && is_target_in && slot_in.slot == DNM_FIRST_SLOT_5 + 5'h07 && rx_enable_down_slot_23
    |=> sport_out.valid) else $error("slot 23 enabled but not forwarded");

  // ==========================================
  // Coverage
  cov_forward: cover property (@(posedge mclk_in) sport_out.valid);
  cov_commit: cover property (@(posedge mclk_in) new_structure_commit_in && state.pending != active);
  cov_zero: cover property (@(posedge mclk_in) nrst_in && use_slot_count_out && is_target_in);
  cov_read_pending: cover property (@(posedge mclk_in) nrst_in && rvalid_out && rdata_out != active);
endmodule // dnm_rx_mask
`default_nettype wire

// ---- design/dnm_pkg.sv ----
`default_nettype none
package dnm_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] DNM_MASK_OFFSET = 8'h67;
  localparam logic [7:0] DNM_MASK_RESET = 8'h00;
  localparam int DNM_FIRST_SLOT = 16;
  localparam int DNM_MASK_WIDTH = 8;
  localparam logic [4:0] DNM_FIRST_SLOT_5 = 5'h10;

  // ==========================================
  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dnm_req_t;

  // Slot stream
  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic [31:0] data;
  } dnm_slot_t;
endpackage
`default_nettype wire

// ---- design/dnm_apply.sv ----
`timescale 1ns/100ps
`default_nettype none
module dnm_apply (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Pending mask and commit
  input wire logic [7:0] pending_in,
  input wire logic commit_in,
  // Active mask
  output logic [7:0] active_out
);
  import dnm_pkg::*;

  typedef struct packed {
    logic [7:0] active;
  } dnm_apply_state_t;

  dnm_apply_state_t state;
  dnm_apply_state_t next_state;

  // ==========================================
  // Commit transfer
  always_comb begin
    next_state = state;
    if (!nrst_in) begin
      next_state.active = DNM_MASK_RESET;
    end else if (commit_in) begin
      next_state.active = pending_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    state <= next_state;
  end

  assign active_out = state.active;

  chk_commit_loads: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    commit_in |=> active_out == $past(pending_in)) else $error("active mask not loaded on commit");
  chk_hold_no_commit: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !commit_in |=> $stable(active_out)) else $error("active mask changed without commit");
endmodule // dnm_apply
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dnm_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  dnm_req_t req_in = '0;
  logic is_target_in = 1'b1;
  logic new_structure_commit_in = 1'b0;
  logic [7:0] local_downstream_slot_count_in = 8'h03;
  dnm_slot_t slot_in = '0;
  logic [7:0] rdata_out;
  logic [7:0] active_mask_out;
  logic [7:0] slot_count_out;
  logic rvalid_out;
  logic use_slot_count_out;
  dnm_slot_t sport_out;
  int n_mismatch = 0;
  int n_compared = 0;
  dnm_rx_mask dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_in(req_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .is_target_in(is_target_in), .new_structure_commit_in(new_structure_commit_in),
    .local_downstream_slot_count_in(local_downstream_slot_count_in), .slot_in(slot_in), .sport_out(sport_out),
    .active_mask_out(active_mask_out), .use_slot_count_out(use_slot_count_out), .slot_count_out(slot_count_out));
  initial forever #12.5 mclk_in = ~mclk_in;
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_op(input logic wr, input logic rd, input logic [7:0] addr, input logic [7:0] wd);
    @(posedge mclk_in);
    req_in <= '{wr: wr, rd: rd, addr: addr, wdata: wd};
    @(posedge mclk_in);
    req_in <= '0;
    #1;
  endtask
  task automatic commit;
    @(posedge mclk_in);
    new_structure_commit_in <= 1'b1;
    @(posedge mclk_in);
    new_structure_commit_in <= 1'b0;
    #1;
  endtask
  task automatic send(input logic [4:0] s, input logic exp);
    @(posedge mclk_in);
    slot_in <= '{valid: 1'b1, slot: s, data: {27'h5A5A5A0, s}};
    @(posedge mclk_in);
    slot_in <= '0;
    #1;
    chk("sport valid", 32'(sport_out.valid), 32'(exp));
    if (exp) chk("sport data", sport_out.data, {27'h5A5A5A0, s});
    if (exp) chk("sport slot", 32'(sport_out.slot), 32'(s));
  endtask
  // ==========================================
  // Scenarios
  task automatic test_pending;
    reg_op(1'b0, 1'b1, DNM_MASK_OFFSET, 8'h00);
    chk("rvalid", 32'(rvalid_out), 32'h1);
    chk("reset read", 32'(rdata_out), 32'(DNM_MASK_RESET));
    chk("use count", 32'(use_slot_count_out), 32'h1);
    chk("count", 32'(slot_count_out), 32'h03);
    reg_op(1'b1, 1'b0, DNM_MASK_OFFSET, 8'h5A);
    chk("rvalid idle", 32'(rvalid_out), 32'h0);
    reg_op(1'b1, 1'b0, 8'h66, 8'hFF);
    reg_op(1'b0, 1'b1, DNM_MASK_OFFSET, 8'h00);
    chk("pending read", 32'(rdata_out), 32'h5A);
    chk("active early", 32'(active_mask_out), 32'h00);
    send(5'h11, 1'b0);
    reg_op(1'b0, 1'b1, 8'h66, 8'h00);
    chk("other read", 32'(rdata_out), 32'h00);
    commit();
    chk("active", 32'(active_mask_out), 32'h5A);
    chk("use count off", 32'(use_slot_count_out), 32'h0);
    $display("test_pending done");
  endtask
  task automatic test_slots;
    logic [7:0] masks [2] = '{8'h5A, 8'hA5};
    foreach (masks[i]) begin
      reg_op(1'b1, 1'b0, DNM_MASK_OFFSET, masks[i]);
      commit();
      for (int s = 14; s <= 25; s++) begin
        send(5'(s), (s >= 16 && s <= 23) ? masks[i][s - 16] : 1'b0);
      end
    end
    $display("test_slots done");
  endtask
  task automatic test_controller;
    @(posedge mclk_in);
    is_target_in <= 1'b0;
    send(5'h10, 1'b0);
    chk("ctrl use count", 32'(use_slot_count_out), 32'h1);
    @(posedge mclk_in);
    is_target_in <= 1'b1;
    reg_op(1'b1, 1'b0, DNM_MASK_OFFSET, 8'h00);
    @(posedge mclk_in);
    local_downstream_slot_count_in <= 8'h07;
    commit();
    chk("zero use count", 32'(use_slot_count_out), 32'h1);
    chk("zero count", 32'(slot_count_out), 32'h07);
    send(5'h10, 1'b0);
    $display("test_controller done");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    test_pending();
    test_slots();
    test_controller();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
